// ==== shared/pie_defines.svh ====
// Register indices, field positions, reset values and codes for the PHY interrupt/counter bank
`ifndef PIE_DEFINES_SVH
`define PIE_DEFINES_SVH

// Register indices; byte address is four times the index
`define PIE_IDX_IRQ_CTRL   6'h12
`define PIE_IDX_PAGE       6'h13
`define PIE_IDX_FC_CNT     6'h14
`define PIE_IDX_RX_CNT     6'h15
`define PIE_IDX_PHY_CTL2   6'h20
`define PIE_IDX_CF_CFG     6'h21
`define PIE_IDX_IRQ_STAT   6'h22
`define PIE_IDX_IRQ_MASK   6'h23
`define PIE_IDX_WIN_LO     6'h14
`define PIE_IDX_WIN_HI     6'h1F

// Field positions
`define PIE_EV_W           6
`define PIE_FLAG_LSB       8
`define PIE_CTL2_SEL_LSB   7
`define PIE_CF_SEL_LSB     6
`define PIE_SEL_W          2
`define PIE_PAGE_W         3
`define PIE_CNT_W          8
`define PIE_EV_LINK        5
`define PIE_EV_SPEED       4
`define PIE_EV_DUPLEX      3
`define PIE_EV_ANEG        2
`define PIE_EV_CTR         1
`define PIE_EV_RXF         0

// Reset values and limits
`define PIE_EN_RST         6'h00
`define PIE_PAGE_RST       3'h0
`define PIE_CNT_RST        8'h00
`define PIE_CNT_MAX        8'hFF
`define PIE_SEL_RST        2'h0

// Bus answers
`define PIE_RESP_OKAY      2'h0
`define PIE_RESP_SLVERR    2'h2

`endif

// ==== shared/pie_pkg.sv ====
// Types for the PHY interrupt enable, page select and error counter bank
package pie_pkg;

    typedef enum logic [2:0] {
        PIE_PAGE_EXT  = 3'b000,
        PIE_PAGE_TEST = 3'b001,
        PIE_PAGE_DIAG = 3'b010,
        PIE_PAGE_SFC  = 3'b101
    } pie_page_type;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } pie_axil_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pie_axil_rsp_type;

    typedef struct packed {
        logic link_change;
        logic speed_change;
        logic duplex_change;
        logic autoneg_done;
        logic control_frame;
        logic false_carrier;
        logic carrier_valid;
        logic invalid_symbol;
        logic collision;
    } pie_phy_ev_type;

endpackage

// ==== src/pie_regs.sv ====
// PHY interrupt enables, page selector and saturating clear-on-read error counters
//
// How it works
// - Bit 4 RW enable, reset 0, gates speed change interrupt.
// - Bit 3 RW enable, reset 0, gates duplex change interrupt.
// - Bit 2 RW enable, reset 0, gates autonegotiation complete interrupt.
// - Selectors zero: bit 1 gates false carrier counter half-full.
// - Any selector bit set: bit 1 gates either counter half-full.
// - Selectors zero: bit 0, reset 0, gates receive error counter half-full.
// - Any selector bit set: bit 0 gates control frame event.
// - Three-bit RW page selector, reset 0, picks page at 14h..1Fh.
// - Page 0 extended, 1 test, 2 diagnostics, 5 status-frame config.
// - Reserved upper bits of page and counters read zero, writes ignored.
// - False carrier count, 8 bits, one per event, read-only, cleared by read.
// - False carrier count sticks at FFh until read.
// - Receive error count bumps on invalid symbol during valid carrier, clear on read.
// - Receive error count bumps at most once per carrier event.
// - No receive error count for a carrier event with collision.
// - Receive error count sticks at maximum until read.
// - Upper status flags latch events, cleared by the read returning them.
// - Bit 5 RW enable, reset 0, gates link change interrupt.
`timescale 1ns/1ps
`include "pie_defines.svh"

module pie_regs (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire pie_pkg::pie_axil_req_type axil_req,
    output pie_pkg::pie_axil_rsp_type      axil_rsp,
    input  wire pie_pkg::pie_phy_ev_type   phy_ev,
    output logic [`PIE_PAGE_W-1:0]         page_select,
    output logic                           irq
);

    // Merge a 32-bit write into a 16-bit register under the byte strobes
    function automatic logic [15:0] wr_merge(input logic [15:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
        logic [15:0] res;
        res = old_v;
        if (strb[0]) begin
            res[7:0] = new_v[7:0];
        end
        if (strb[1]) begin
            res[15:8] = new_v[15:8];
        end
        return res;
    endfunction

    function automatic logic in_window(input logic [5:0] idx);
        return (idx >= `PIE_IDX_WIN_LO) && (idx <= `PIE_IDX_WIN_HI);
    endfunction

    pie_pkg::pie_axil_rsp_type     rsp_q;
    logic                          aw_held_q;
    logic                          w_held_q;
    logic [7:0]                    awaddr_q;
    logic [31:0]                   wdata_q;
    logic [3:0]                    wstrb_q;
    logic [`PIE_EV_W-1:0]          en_q;
    logic [`PIE_EV_W-1:0]          flag_q;
    logic [`PIE_EV_W-1:0]          stat_q;
    logic [`PIE_EV_W-1:0]          mask_q;
    logic [`PIE_PAGE_W-1:0]        page_q;
    logic [`PIE_SEL_W-1:0]         ctl2_sel_q;
    logic [`PIE_SEL_W-1:0]         cf_sel_q;
    logic [`PIE_CNT_W-1:0]         fc_cnt_q;
    logic [`PIE_CNT_W-1:0]         fc_cnt_d;
    logic [`PIE_CNT_W-1:0]         rx_cnt_q;
    logic [`PIE_CNT_W-1:0]         rx_cnt_d;
    logic                          car_q;
    logic                          err_seen_q;
    logic                          col_seen_q;
    logic                          irq_q;
    logic                          wr_fire;
    logic                          rd_fire;
    logic [5:0]                    wr_idx;
    logic [5:0]                    rd_idx;
    logic                          page0;
    logic                          clr_fc;
    logic                          clr_rx;
    logic                          clr_flag;
    logic                          carrier_end;
    logic                          rx_inc;
    logic                          alt_mode;
    logic                          fc_half;
    logic                          rx_half;
    logic [`PIE_EV_W-1:0]          ev_raw;
    logic [15:0]                   rd_word;
    logic                          rd_hit;
    logic [15:0]                   wr_word;

    assign axil_rsp    = rsp_q;
    assign page_select = page_q;
    assign irq         = irq_q;

    assign wr_fire = aw_held_q && w_held_q && !rsp_q.bvalid;
    assign rd_fire = axil_req.arvalid && rsp_q.arready;
    assign wr_idx  = awaddr_q[7:2];
    assign rd_idx  = axil_req.araddr[7:2];
    assign page0   = (page_q == pie_pkg::PIE_PAGE_EXT);

    // Counters only answer on the extended page; other pages belong elsewhere
    assign clr_fc   = rd_fire && page0 && (rd_idx == `PIE_IDX_FC_CNT);
    assign clr_rx   = rd_fire && page0 && (rd_idx == `PIE_IDX_RX_CNT);
    assign clr_flag = rd_fire && (rd_idx == `PIE_IDX_IRQ_CTRL);

    // Both channels in one process: the response struct may have only one writer
    // Address and data taken in either order, one write in flight
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_q.arready <= 1'b1;
            rsp_q.rvalid  <= 1'b0;
            rsp_q.rdata   <= 32'h0000_0000;
            rsp_q.rresp   <= `PIE_RESP_OKAY;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            rsp_q.awready <= 1'b1;
            rsp_q.wready  <= 1'b1;
            rsp_q.bvalid  <= 1'b0;
            rsp_q.bresp   <= `PIE_RESP_OKAY;
        end else begin
            if (axil_req.awvalid && rsp_q.awready) begin
                aw_held_q     <= 1'b1;
                awaddr_q      <= axil_req.awaddr;
                rsp_q.awready <= 1'b0;
            end
            if (axil_req.wvalid && rsp_q.wready) begin
                w_held_q     <= 1'b1;
                wdata_q      <= axil_req.wdata;
                wstrb_q      <= axil_req.wstrb;
                rsp_q.wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp  <= (in_window(wr_idx) || wr_idx == `PIE_IDX_IRQ_CTRL ||
                                 wr_idx == `PIE_IDX_PAGE || wr_idx == `PIE_IDX_PHY_CTL2 ||
                                 wr_idx == `PIE_IDX_CF_CFG || wr_idx == `PIE_IDX_IRQ_STAT ||
                                 wr_idx == `PIE_IDX_IRQ_MASK) ? `PIE_RESP_OKAY
                                                               : `PIE_RESP_SLVERR;
            end
            if (rsp_q.bvalid && axil_req.bready) begin
                rsp_q.bvalid  <= 1'b0;
                rsp_q.awready <= 1'b1;
                rsp_q.wready  <= 1'b1;
            end
            // Read answers one cycle after the address is taken
            if (rd_fire) begin
                rsp_q.arready <= 1'b0;
                rsp_q.rvalid  <= 1'b1;
                rsp_q.rdata   <= {16'h0000, rd_word};
                rsp_q.rresp   <= rd_hit ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
            end else if (rsp_q.rvalid && axil_req.rready) begin
                rsp_q.rvalid  <= 1'b0;
                rsp_q.arready <= 1'b1;
            end
        end
    end

    // Read decode; reserved bits come back as zero
    always_comb begin
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        unique case (rd_idx)
            `PIE_IDX_IRQ_CTRL: rd_word = {2'h0, flag_q, 2'h0, en_q};
            `PIE_IDX_PAGE:     rd_word = {13'h0000, page_q};
            `PIE_IDX_PHY_CTL2: rd_word = {7'h00, ctl2_sel_q, 7'h00};
            `PIE_IDX_CF_CFG:   rd_word = {8'h00, cf_sel_q, 6'h00};
            `PIE_IDX_IRQ_STAT: rd_word = {10'h000, stat_q};
            `PIE_IDX_IRQ_MASK: rd_word = {10'h000, mask_q};
            default: begin
                rd_hit = in_window(rd_idx);
                if (page0 && rd_idx == `PIE_IDX_FC_CNT) begin
                    rd_word = {8'h00, fc_cnt_q};
                end else if (page0 && rd_idx == `PIE_IDX_RX_CNT) begin
                    rd_word = {8'h00, rx_cnt_q};
                end
            end
        endcase
    end

    // Software-written control
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q       <= `PIE_EN_RST;
            page_q     <= `PIE_PAGE_RST;
            ctl2_sel_q <= `PIE_SEL_RST;
            cf_sel_q   <= `PIE_SEL_RST;
            mask_q     <= `PIE_EN_RST;
        end else if (wr_fire) begin
            unique case (wr_idx)
                `PIE_IDX_IRQ_CTRL: en_q <= wr_word[`PIE_EV_W-1:0];
                `PIE_IDX_PAGE:     page_q <= wr_word[`PIE_PAGE_W-1:0];
                `PIE_IDX_PHY_CTL2: ctl2_sel_q <= wr_word[`PIE_CTL2_SEL_LSB +: `PIE_SEL_W];
                `PIE_IDX_CF_CFG:   cf_sel_q <= wr_word[`PIE_CF_SEL_LSB +: `PIE_SEL_W];
                `PIE_IDX_IRQ_MASK: mask_q <= wr_word[`PIE_EV_W-1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (wr_idx)
            `PIE_IDX_IRQ_CTRL: wr_word = wr_merge({10'h000, en_q}, wdata_q, wstrb_q);
            `PIE_IDX_PAGE:     wr_word = wr_merge({13'h0000, page_q}, wdata_q, wstrb_q);
            `PIE_IDX_PHY_CTL2: wr_word = wr_merge({7'h00, ctl2_sel_q, 7'h00}, wdata_q, wstrb_q);
            `PIE_IDX_CF_CFG:   wr_word = wr_merge({8'h00, cf_sel_q, 6'h00}, wdata_q, wstrb_q);
            `PIE_IDX_IRQ_MASK: wr_word = wr_merge({10'h000, mask_q}, wdata_q, wstrb_q);
            default:           wr_word = wr_merge(16'h0000, wdata_q, wstrb_q);
        endcase
    end

    // Carrier tracking: receive errors are judged once, when the carrier ends
    assign carrier_end = car_q && !phy_ev.carrier_valid;
    assign rx_inc      = carrier_end && err_seen_q && !col_seen_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            car_q      <= 1'b0;
            err_seen_q <= 1'b0;
            col_seen_q <= 1'b0;
        end else begin
            car_q <= phy_ev.carrier_valid;
            if (phy_ev.carrier_valid) begin
                err_seen_q <= err_seen_q || phy_ev.invalid_symbol;
                col_seen_q <= col_seen_q || phy_ev.collision;
            end else begin
                err_seen_q <= 1'b0;
                col_seen_q <= 1'b0;
            end
        end
    end

    // Clear then count, so an event in the reading cycle survives as one
    always_comb begin
        fc_cnt_d = clr_fc ? `PIE_CNT_RST : fc_cnt_q;
        if (phy_ev.false_carrier && fc_cnt_d != `PIE_CNT_MAX) begin
            fc_cnt_d = fc_cnt_d + 8'h01;
        end
        rx_cnt_d = clr_rx ? `PIE_CNT_RST : rx_cnt_q;
        if (rx_inc && rx_cnt_d != `PIE_CNT_MAX) begin
            rx_cnt_d = rx_cnt_d + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fc_cnt_q <= `PIE_CNT_RST;
            rx_cnt_q <= `PIE_CNT_RST;
        end else begin
            fc_cnt_q <= fc_cnt_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // Event mapping; the two low enables change meaning with the selectors
    assign fc_half  = !fc_cnt_q[`PIE_CNT_W-1] && fc_cnt_d[`PIE_CNT_W-1];
    assign rx_half  = !rx_cnt_q[`PIE_CNT_W-1] && rx_cnt_d[`PIE_CNT_W-1];
    assign alt_mode = (|ctl2_sel_q) || (|cf_sel_q);

    always_comb begin
        ev_raw                = '0;
        ev_raw[`PIE_EV_LINK]  = phy_ev.link_change;
        ev_raw[`PIE_EV_SPEED] = phy_ev.speed_change;
        ev_raw[`PIE_EV_DUPLEX] = phy_ev.duplex_change;
        ev_raw[`PIE_EV_ANEG]  = phy_ev.autoneg_done;
        ev_raw[`PIE_EV_CTR]   = alt_mode ? (fc_half || rx_half) : fc_half;
        ev_raw[`PIE_EV_RXF]   = alt_mode ? phy_ev.control_frame : rx_half;
    end

    // Pending flags clear on read; a new event in that cycle wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= (clr_flag ? '0 : flag_q) | ev_raw;
        end
    end

    // Sticky status takes only enabled events; write one to clear, set wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= '0;
        end else begin
            if (wr_fire && wr_idx == `PIE_IDX_IRQ_STAT) begin
                stat_q <= (stat_q & ~wr_word[`PIE_EV_W-1:0]) | (ev_raw & en_q);
            end else begin
                stat_q <= stat_q | (ev_raw & en_q);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_fc_count;
        phy_ev.false_carrier && !clr_fc && fc_cnt_q != 8'hFF |=> fc_cnt_q == $past(fc_cnt_q) + 8'h01;
    endproperty
    a_fc_count: assert property (p_fc_count) else $error("false carrier count missed");

    property p_fc_stick;
        fc_cnt_q == 8'hFF && !clr_fc |=> fc_cnt_q == 8'hFF;
    endproperty
    a_fc_stick: assert property (p_fc_stick) else $error("false carrier count wrapped");

    property p_rx_stick;
        rx_cnt_q == 8'hFF && !clr_rx |=> rx_cnt_q == 8'hFF;
    endproperty
    a_rx_stick: assert property (p_rx_stick) else $error("rx error count wrapped");

    property p_rx_once;
        !carrier_end |=> rx_cnt_q <= $past(rx_cnt_q);
    endproperty
    a_rx_once: assert property (p_rx_once) else $error("rx error count rose mid carrier");

    property p_rx_col;
        carrier_end && col_seen_q && !clr_rx |=> $stable(rx_cnt_q);
    endproperty
    a_rx_col: assert property (p_rx_col) else $error("rx count rose despite collision");

    property p_rx_count;
        phy_ev.carrier_valid && phy_ev.invalid_symbol && !phy_ev.collision && !col_seen_q
        ##1 !phy_ev.carrier_valid && !clr_rx && rx_cnt_q < 8'hFF
        |=> rx_cnt_q == $past(rx_cnt_q) + 8'h01;
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("rx error count missed");

    property p_page_wr;
        wr_fire && wr_idx == `PIE_IDX_PAGE && wstrb_q[0]
        |=> page_q == $past(wdata_q[2:0]) ##2 page_select == $past(page_q, 2);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page select not written");

    property p_resv_zero;
        rd_fire && (rd_idx == `PIE_IDX_PAGE || rd_idx == `PIE_IDX_FC_CNT ||
                    rd_idx == `PIE_IDX_RX_CNT)
        |=> axil_rsp.rvalid && axil_rsp.rdata[31:8] == 24'h000000 &&
            (rd_idx != `PIE_IDX_PAGE || axil_rsp.rdata[7:3] == 5'h00);
    endproperty
    a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

    property p_half_fc;
        !alt_mode && fc_half && en_q[1] |=> stat_q[1] ##1 (irq || !mask_q[1]);
    endproperty
    a_half_fc: assert property (p_half_fc) else $error("false carrier half-full lost");

    property p_half_rx_alt;
        alt_mode && rx_half && en_q[1] |=> stat_q[1];
    endproperty
    a_half_rx_alt: assert property (p_half_rx_alt) else $error("either-counter event lost");

    property p_cf_alt;
        alt_mode && phy_ev.control_frame && en_q[0] |=> stat_q[0];
    endproperty
    a_cf_alt: assert property (p_cf_alt) else $error("control frame event lost");

    property p_rx_half;
        !alt_mode && rx_half && !wr_fire |=> stat_q[0] == ($past(stat_q[0]) || $past(en_q[0]));
    endproperty
    a_rx_half: assert property (p_rx_half) else $error("rx half-full status wrong");

    property p_speed_flag;
        phy_ev.speed_change |=> flag_q[4] &&
            (stat_q[4] == ($past(stat_q[4]) || $past(en_q[4])) || $past(wr_fire));
    endproperty
    a_speed_flag: assert property (p_speed_flag) else $error("speed flag not latched");

    c_fc_sat:  cover property (fc_cnt_q == 8'hFF ##1 clr_fc);
    c_rx_inc:  cover property (rx_inc);
    c_irq:     cover property ($rose(irq));
    c_alt_cf:  cover property (alt_mode && phy_ev.control_frame && en_q[0]);

endmodule // pie_regs

// ==== verif/phy_irq_enable_page_and_error_counters_tb.sv ====
// Self-checking bench for the PHY interrupt enable, page and counter bank
`timescale 1ns/1ps
`include "pie_defines.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module phy_irq_enable_page_and_error_counters_tb;
    typedef struct packed {
        logic [5:0]  idx;
        logic [15:0] wd;
        logic [15:0] rd;
    } pie_row_type;
    logic                      clk = 1'b0;
    logic                      sys_rst = 1'b1;
    pie_pkg::pie_axil_req_type req;
    pie_pkg::pie_axil_rsp_type rsp;
    pie_pkg::pie_phy_ev_type   ev = '0;
    logic [2:0]                page_select;
    logic                      irq;
    logic [31:0]               rdat;
    logic [1:0]                resp;
    int                        n_errors = 0;
    int                        checked = 0;
    int                        cycles = 0;
    pie_row_type               rows [14] = '{
        '{`PIE_IDX_IRQ_MASK, 16'hFFFF, 16'h003F},
        '{`PIE_IDX_PHY_CTL2, 16'hFFFF, 16'h0180},
        '{`PIE_IDX_PHY_CTL2, 16'h0000, 16'h0000},
        '{`PIE_IDX_CF_CFG, 16'hFFFF, 16'h00C0},
        '{`PIE_IDX_CF_CFG, 16'h0000, 16'h0000},
        '{`PIE_IDX_IRQ_CTRL, 16'hFFFF, 16'h003F},
        '{`PIE_IDX_IRQ_CTRL, 16'h0015, 16'h0015},
        '{`PIE_IDX_PAGE, 16'hFFFF, 16'h0007},
        '{`PIE_IDX_PAGE, 16'h0005, 16'h0005},
        '{`PIE_IDX_FC_CNT, 16'h00AA, 16'h0000},
        '{`PIE_IDX_PAGE, 16'h0002, 16'h0002},
        '{`PIE_IDX_PAGE, 16'h0000, 16'h0000},
        '{`PIE_IDX_FC_CNT, 16'hFFFF, 16'h0000},
        '{`PIE_IDX_RX_CNT, 16'hFFFF, 16'h0000}};

    always #25 clk = ~clk;

    pie_regs i_pie_regs (
        .clk(clk), .sys_rst(sys_rst), .axil_req(req), .axil_rsp(rsp),
        .phy_ev(ev), .page_select(page_select), .irq(irq));
    pie_axil_master i_pie_axil_master (.clk(clk), .req(req), .rsp(rsp));

    task automatic finish_test();
        $display("checks=%0d errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Run is a few thousand cycles; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic wr(input logic [5:0] i, input logic [15:0] d);
        i_pie_axil_master.write(i, d, resp);
        `CHK(resp, `PIE_RESP_OKAY)
    endtask

    task automatic rd_chk(input logic [5:0] i, input logic [15:0] e);
        i_pie_axil_master.read(i, rdat, resp);
        `CHK(rdat, {16'h0000, e})
        `CHK(resp, `PIE_RESP_OKAY)
    endtask

    // A pulse held n cycles counts n events
    task automatic pulse(input pie_pkg::pie_phy_ev_type p, input int n);
        @(posedge clk);
        ev <= p;
        repeat (n) @(posedge clk);
        ev <= '0;
    endtask

    task automatic rxc(input int n, input logic col);
        repeat (n) begin
            @(posedge clk);
            ev.carrier_valid <= 1'b1;
            ev.collision     <= col;
            @(posedge clk);
            ev.invalid_symbol <= 1'b1;
            repeat (3) @(posedge clk);
            ev.invalid_symbol <= 1'b0;
            ev.carrier_valid  <= 1'b0;
            ev.collision      <= 1'b0;
        end
    endtask

    task automatic clr_irq();
        wr(`PIE_IDX_IRQ_STAT, 16'h003F);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        `CHK(page_select, `PIE_PAGE_RST)
        `CHK(irq, 1'b0)
        for (int k = 0; k < 4; k++) begin
            rd_chk(6'(`PIE_IDX_IRQ_CTRL + k), 16'h0000);
        end
        for (int k = 0; k < 14; k++) begin
            wr(rows[k].idx, rows[k].wd);
            rd_chk(rows[k].idx, rows[k].rd);
            if (rows[k].idx == `PIE_IDX_PAGE) `CHK(page_select, rows[k].rd[2:0])
        end
        i_pie_axil_master.write(6'h30, 16'hFFFF, resp);
        `CHK(resp, `PIE_RESP_SLVERR)
        i_pie_axil_master.read(6'h30, rdat, resp);
        `CHK(resp, `PIE_RESP_SLVERR)
        wr(`PIE_IDX_IRQ_CTRL, 16'h0003);
        wr(`PIE_IDX_IRQ_MASK, 16'h003F);
        pulse(9'h008, 3);
        rd_chk(`PIE_IDX_FC_CNT, 16'h0003);
        rd_chk(`PIE_IDX_FC_CNT, 16'h0000);
        pulse(9'h008, 300);
        rd_chk(`PIE_IDX_FC_CNT, 16'h00FF);
        `CHK(irq, 1'b1)
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h0203);
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h0003);
        clr_irq();
        rxc(1, 1'b0);
        rxc(1, 1'b1);
        rd_chk(`PIE_IDX_RX_CNT, 16'h0001);
        rxc(300, 1'b0);
        rd_chk(`PIE_IDX_RX_CNT, 16'h00FF);
        `CHK(irq, 1'b1)
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h0103);
        rd_chk(`PIE_IDX_IRQ_STAT, 16'h0001);
        clr_irq();
        // Selector bit set: both counter enables change meaning
        wr(`PIE_IDX_PHY_CTL2, 16'h0080);
        rxc(130, 1'b0);
        `CHK(irq, 1'b1)
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h0203);
        clr_irq();
        pulse(9'h010, 1);
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h0103);
        clr_irq();
        pulse(9'h1E0, 1);
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h3C03);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(`PIE_IDX_IRQ_CTRL, 16'h0010);
        pulse(9'h080, 1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(`PIE_IDX_PAGE, 16'h0002);
        `CHK(page_select, 3'h2)
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        `CHK(page_select, `PIE_PAGE_RST)
        rd_chk(`PIE_IDX_IRQ_CTRL, 16'h0000);
        finish_test();
    end
endmodule // phy_irq_enable_page_and_error_counters_tb

// ==== verif/pie_axil_master.sv ====
// AXI4-Lite master model standing in for the management software
`timescale 1ns/1ps
module pie_axil_master (
    input  wire logic                      clk,
    output pie_pkg::pie_axil_req_type      req,
    input  wire pie_pkg::pie_axil_rsp_type rsp
);
    initial req = '0;

    // Sampled mid-cycle: responses only move on rising edges
    task automatic write(input logic [5:0] idx, input logic [15:0] d,
                         output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk);
        req.awaddr  <= {idx, 2'b00};
        req.wdata   <= {16'h0000, d};
        req.wstrb   <= 4'h3;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        while (!b) begin
            @(negedge clk);
            aw = req.awvalid & rsp.awready;
            w  = req.wvalid & rsp.wready;
            b  = rsp.bvalid;
            r  = rsp.bresp;
            @(posedge clk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
        end
        req.bready <= 1'b0;
    endtask

    task automatic read(input logic [5:0] idx, output logic [31:0] d,
                        output logic [1:0] r);
        logic ar, v;
        v = 1'b0;
        @(posedge clk);
        req.araddr  <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        while (!v) begin
            @(negedge clk);
            ar = req.arvalid & rsp.arready;
            v  = rsp.rvalid;
            d  = rsp.rdata;
            r  = rsp.rresp;
            @(posedge clk);
            if (ar) req.arvalid <= 1'b0;
        end
        req.rready <= 1'b0;
    endtask
endmodule // pie_axil_master
